// *** rtl/axfo_pkg.sv ***
package axfo_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 32'h00000014;
    localparam int unsigned MS_NS          = 32'h000f4240;
    localparam int unsigned MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [31:0] CLK_HZ         = 32'h02faf080;

    // ------------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_SELECT    = 8'h04;
    localparam logic [7:0] OFS_TARGET    = 8'h08;
    localparam logic [7:0] OFS_SPEED     = 8'h0c;
    localparam logic [7:0] OFS_DWELL     = 8'h10;
    localparam logic [7:0] OFS_AUX_CODE  = 8'h14;
    localparam logic [7:0] OFS_MODE      = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1c;
    localparam logic [7:0] OFS_POSITION  = 8'h20;
    localparam logic [7:0] OFS_AUX_OUT   = 8'h24;
    localparam logic [7:0] OFS_ERR_RESET = 8'h28;

    // Field positions.
    localparam int unsigned CTRL_FLOAT_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned CTRL_STOP_BIT  = 2;
    localparam int unsigned MODE_CTRL_BIT  = 0;
    localparam int unsigned MODE_COORD_BIT = 1;
    localparam int unsigned MODE_RAMP_LSB  = 2;
    localparam int unsigned SEL_WIDTH      = 24;

    // Reset values.
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    // ------------------------------------------------------------------
    // Operand limits and status codes
    // ------------------------------------------------------------------
    localparam logic [31:0] SPEED_MAX      = 32'h000186a0;
    localparam logic [31:0] DWELL_MAX      = 32'h0000c350;
    localparam logic [16:0] AUX_CODE_MAX   = 17'h10063;
    localparam logic [7:0]  STAT_OK        = 8'h00;
    localparam logic [7:0]  STAT_BAD_AXIS  = 8'h01;
    localparam logic [7:0]  STAT_BAD_VALUE = 8'h02;
    localparam logic [7:0]  STAT_NO_ORIGIN = 8'he0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic signed [31:0] target;
        logic [31:0]        speed;
        logic [31:0]        dwell;
        logic [15:0]        auxCode;
        logic               controlTypeSel;
        logic               coordinateSel;
        logic [1:0]         rampSel;
    } axfo_move_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } axfo_bus_phase_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DWELL,
        ST_SCAN_WAIT,
        ST_COMPLETE
    } axfo_state_type;

endpackage

// *** rtl/axfo_axis_cmd.sv ***
`timescale 1ns/1ps
// Overview of operation
// [R1] Floating-origin request edge acts on selected axis.
// [R2] Floating origin zeroes position, sets origin flag.
// [R3] Floating origin produces no motion or pulses.
// [R4] Floating origin ignored while busy or error.
// [R5] Host clears errors before floating origin.
// [R6] Host selects start step after floating origin.
// [R7] Direct start takes move data from operands.
// [R8] Target is full-range signed 32-bit pulse position.
// [R9] Speed operand limited to zero..100000.
// [R10] Dwell operand limited to zero..50000.
// [R11] Aux code is 16-bit, documented limit 65635.
// [R12] Control select: 0 position, 1 speed.
// [R13] Coordinate select: 0 absolute, 1 incremental.
// [R14] Ramp selector 0..3 picks time set 1..4.
// [R15] Direct start on rising edge, not busy/error.
// [R16] No origin: report code 224, no motion.
// [R17] After positioning, copy aux code to output word.
// [R18] Stop output, wait dwell, then complete.
// [R19] Completion flag stands exactly one scan.
// [R20] Base, slot, axis all zero selects axis X.
module axfo_axis_cmd
    import axfo_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
)
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             pulseOut,
    output logic             dirOut,
    output logic [1:0]       rampSel,
    output logic             axisBusy,
    output logic             axisError,
    output logic             originDetermined,
    output logic             posComplete,
    output logic [15:0]      auxCodeWord,
    output logic [7:0]       statCode
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    axfo_bus_phase_type dataPhase;
    logic [2:0]         controlReg;
    logic [2:0]         controlPrev;
    logic [SEL_WIDTH-1:0] selectReg;
    axfo_move_type      moveParam;
    axfo_move_type      activeMove;
    axfo_state_type     state;
    axfo_state_type     next_state;
    logic signed [31:0] presentPos;
    logic signed [31:0] destPos;
    logic [31:0]        rateAcc;
    logic [31:0]        msCount;
    logic [31:0]        dwellCount;

    // Zero-wait slave; every access ends OKAY in its first data cycle.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire addrPhase = hsel & htrans[1] & hready;
    wire wrValid   = dataPhase.valid & dataPhase.write;

    // Write strobe for one register offset in the data phase.
    function automatic logic wrHit(input logic [7:0] ofs);
        return wrValid && (dataPhase.addr == ofs);
    endfunction

    wire [31:0] statusWord = {16'h0000, statCode, 4'h0, posComplete,
                              originDetermined, axisError, axisBusy};

    // Read mux; unmapped offsets read as zero.
    function automatic logic [31:0] readWord(input logic [7:0] a);
        case (a)
            OFS_CONTROL:  return {29'h0, controlReg};
            OFS_SELECT:   return {8'h00, selectReg};
            OFS_TARGET:   return moveParam.target;
            OFS_SPEED:    return moveParam.speed;
            OFS_DWELL:    return moveParam.dwell;
            OFS_AUX_CODE: return {16'h0000, moveParam.auxCode};
            OFS_MODE:     return {28'h0, moveParam.rampSel,
                                  moveParam.coordinateSel,
                                  moveParam.controlTypeSel};
            OFS_STATUS:   return statusWord;
            OFS_POSITION: return presentPos;
            OFS_AUX_OUT:  return {16'h0000, auxCodeWord};
            default:      return RESET_WORD;
        endcase
    endfunction

    // Address phase capture and registered read data.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dataPhase <= '0;
            hrdata    <= RESET_WORD;
        end
        else
        begin
            if (hready)
                dataPhase <= '{addrPhase, hwrite, haddr[7:0]};
            if (addrPhase && !hwrite)
                hrdata <= readWord(haddr[7:0]);
        end
    end

    // Software-written operand and control registers.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            controlReg <= '0;
            selectReg  <= '0;
            moveParam  <= '0;
        end
        else
        begin
            if (wrHit(OFS_CONTROL))
                controlReg <= hwdata[2:0];
            if (wrHit(OFS_SELECT))
                selectReg <= hwdata[SEL_WIDTH-1:0];
            if (wrHit(OFS_TARGET))
                moveParam.target <= hwdata; // R8
            if (wrHit(OFS_SPEED))
                moveParam.speed <= hwdata;
            if (wrHit(OFS_DWELL))
                moveParam.dwell <= hwdata;
            if (wrHit(OFS_AUX_CODE))
                moveParam.auxCode <= hwdata[15:0];
            if (wrHit(OFS_MODE))
            begin
                moveParam.controlTypeSel <= hwdata[MODE_CTRL_BIT];
                moveParam.coordinateSel  <= hwdata[MODE_COORD_BIT];
                moveParam.rampSel <= hwdata[MODE_RAMP_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire floatEdge = controlReg[CTRL_FLOAT_BIT]
                   & ~controlPrev[CTRL_FLOAT_BIT];           // R1
    wire startEdge = controlReg[CTRL_START_BIT]
                   & ~controlPrev[CTRL_START_BIT];           // R15
    wire stopEdge  = controlReg[CTRL_STOP_BIT]
                   & ~controlPrev[CTRL_STOP_BIT];
    wire errReset  = wrHit(OFS_ERR_RESET) & hwdata[0];       // R5
    wire axisSelOk = (selectReg == '0);                      // R20
    wire cmdBlocked = axisBusy | axisError;                  // R4 R15
    wire operandOk = (moveParam.speed <= SPEED_MAX)          // R9
                   && (moveParam.dwell <= DWELL_MAX)         // R10
                   && ({1'b0, moveParam.auxCode} <= AUX_CODE_MAX); // R11

    wire floatReq   = floatEdge & ~cmdBlocked;               // R4
    wire floatGo    = floatReq & axisSelOk;                  // R1
    wire startReq   = startEdge & ~cmdBlocked;               // R15
    wire startNoOrg = startReq & ~originDetermined;          // R16
    wire startBadSel = (startReq & originDetermined & ~axisSelOk)
                     | (floatReq & ~axisSelOk);
    wire startBadVal = startReq & originDetermined & axisSelOk
                     & ~operandOk;
    wire startGo    = startReq & originDetermined & axisSelOk
                    & operandOk;

    // Destination: absolute target or offset from present position.
    wire signed [31:0] incDest = 32'(presentPos + moveParam.target);
    wire signed [31:0] newDest = moveParam.coordinateSel
                               ? incDest : moveParam.target; // R13

    // ------------------------------------------------------------------
    // Timing: millisecond tick doubles as the scan boundary
    // ------------------------------------------------------------------
    wire msTick = (msCount == MS_CYCLES - 1);

    always_ff @(posedge mclk)
    begin
        if (reset)
            msCount <= '0;
        else
            msCount <= msTick ? '0 : msCount + 32'h1;
    end

    // Pulse rate: add speed each cycle, one pulse per CLK_HZ overflow.
    wire [32:0] rateSum  = {1'b0, rateAcc} + {1'b0, activeMove.speed};
    wire        rateDue  = rateSum >= {1'b0, CLK_HZ};
    wire [32:0] rateLess = rateSum - {1'b0, CLK_HZ};
    wire        atTarget = (presentPos == destPos);
    wire        posMode  = ~activeMove.controlTypeSel;        // R12
    wire        stepNow  = (state == ST_RUN) && rateDue
                         && !(posMode && atTarget);
    wire        dwellDone = (dwellCount >= activeMove.dwell);

    // ------------------------------------------------------------------
    // Move sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (startGo)
                    next_state = ST_RUN;
            ST_RUN:
                if (posMode ? atTarget : stopEdge)           // R12
                    next_state = ST_DWELL;                   // R18
            ST_DWELL:
                if (dwellDone)
                    next_state = ST_SCAN_WAIT;               // R18
            ST_SCAN_WAIT:
                if (msTick)
                    next_state = ST_COMPLETE;
            ST_COMPLETE:
                if (msTick)
                    next_state = ST_IDLE;                    // R19
        endcase
    end

    // State, busy and completion flags.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state       <= ST_IDLE;
            axisBusy    <= 1'b0;
            posComplete <= 1'b0;
            controlPrev <= '0;
        end
        else
        begin
            state       <= next_state;
            axisBusy    <= (next_state != ST_IDLE);
            posComplete <= (next_state == ST_COMPLETE);       // R19
            controlPrev <= controlReg;
        end
    end

    // Latch operands at start; copy aux code once the move is done.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            activeMove  <= '0;
            destPos     <= '0;
            auxCodeWord <= '0;
            rampSel     <= '0;
        end
        else if (startGo)
        begin
            activeMove <= moveParam;                         // R7
            destPos    <= newDest;                           // R8
            rampSel    <= moveParam.rampSel;                 // R14
        end
        else if (state == ST_SCAN_WAIT && msTick)
            auxCodeWord <= activeMove.auxCode;               // R17
    end

    // Dwell counter runs in milliseconds after the output stops.
    always_ff @(posedge mclk)
    begin
        if (reset || state != ST_DWELL)
            dwellCount <= '0;
        else if (msTick && !dwellDone)
            dwellCount <= dwellCount + 32'h1;                // R18
    end

    // Position, pulse output and direction.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            presentPos       <= '0;
            originDetermined <= 1'b0;
            rateAcc          <= '0;
            pulseOut         <= 1'b0;
            dirOut           <= 1'b1;
        end
        else
        begin
            pulseOut <= stepNow;
            if (floatGo)
            begin
                presentPos       <= '0;                      // R2 R3
                originDetermined <= 1'b1;                    // R2
            end
            else if (stepNow)
                presentPos <= dirOut ? presentPos + 32'sh1
                                     : presentPos - 32'sh1;
            if (startGo)
            begin
                rateAcc <= '0;
                dirOut  <= moveParam.controlTypeSel
                         ? !moveParam.target[31]
                         : (newDest > presentPos);
            end
            else if (state == ST_RUN)
                rateAcc <= rateDue ? rateLess[31:0] : rateSum[31:0];
        end
    end

    // Error flag and status code; a new error wins over a reset.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            axisError <= 1'b0;
            statCode  <= STAT_OK;
        end
        else
        begin
            axisError <= startBadVal | (axisError & ~errReset);
            if (startNoOrg)
                statCode <= STAT_NO_ORIGIN;                  // R16
            else if (startBadSel)
                statCode <= STAT_BAD_AXIS;
            else if (startBadVal)
                statCode <= STAT_BAD_VALUE;
            else if (startGo || floatGo || errReset)
                statCode <= STAT_OK;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence sDoneScan;
        (state == ST_SCAN_WAIT) && msTick ##1 posComplete;
    endsequence

    sequence sFloatTaken;
        floatGo ##1 (presentPos == 0);
    endsequence

    a_float_zeroes_pos: assert property (floatGo |=>   // R2
        presentPos == 0 && originDetermined)
        else $error("floating origin did not zero position");

    a_float_no_pulse: assert property (sFloatTaken |-> // R3
        !pulseOut && !axisBusy ##1 !pulseOut && !axisBusy)
        else $error("floating origin started motion");

    a_float_ignored: assert property (floatEdge && cmdBlocked // R4
        && !stepNow |=> $stable({originDetermined, presentPos}))
        else $error("floating origin taken while blocked");

    a_start_latches: assert property (startGo |=>       // R7
        axisBusy && activeMove == $past(moveParam))
        else $error("direct start did not latch operands");

    a_inc_dest_sum: assert property (startGo           // R13
        && moveParam.coordinateSel |=>
        destPos == 32'($past(presentPos) + $past(moveParam.target)))
        else $error("incremental destination wrong");

    a_start_limits: assert property (startGo |->       // R9
        moveParam.speed <= SPEED_MAX && moveParam.dwell <= DWELL_MAX)
        else $error("direct start accepted bad operand");

    a_start_blocked: assert property (startEdge        // R15
        && axisError && !axisBusy |=> !axisBusy ##1 !axisBusy)
        else $error("direct start taken in error state");

    a_no_origin_code: assert property (startNoOrg |=>  // R16
        statCode == STAT_NO_ORIGIN && !axisBusy)
        else $error("missing origin not reported");

    a_aux_code_copy: assert property (sDoneScan |->    // R17
        auxCodeWord == activeMove.auxCode)
        else $error("aux code not copied on completion");

    a_dwell_before_done: assert property (state == ST_DWELL // R18
        && !dwellDone |=> !posComplete && !pulseOut)
        else $error("completion before dwell ended");

    a_one_scan_flag: assert property (posComplete && msTick // R19
        |=> !posComplete)
        else $error("completion flag longer than one scan");

    a_pos_stop_target: assert property (state == ST_RUN // R12
        && posMode && atTarget |=> state == ST_DWELL)
        else $error("position move overran target");

endmodule // axfo_axis_cmd

// *** verif/axfo_host_model.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------
// Controller-side bus master that issues axis commands
// --------------------------------------------------------------
module axfo_host_model
    import axfo_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             stuck
);
    // The bus idles with no transfer until the first task call.
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
        stuck  = 1'b0;
    end

    // Waits for hready at a rising edge; a hang raises stuck.
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1)
        begin
            stuck <= 1'b1;
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        hsel   <= 1'b0;
        hwdata <= ~d; // Released data never repeats the last word.
    endtask

    // Register write and read helpers.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(a, 1'b1, d, unused);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(a, 1'b0, 32'h00000000, r);
    endtask

    // Clears a pending axis error before further commands.
    task automatic clear_error();
        wr(OFS_ERR_RESET, 32'h00000001);
    endtask
endmodule // axfo_host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import axfo_pkg::*;
;
    localparam int MS = 10;
    typedef struct {
        logic [31:0] target;
        logic [31:0] speed;
        logic [31:0] dwell;
        logic [15:0] aux;
        logic [31:0] mode;
        logic [31:0] expPos;
        int          expPulses;
        logic        expDir;
    } axfo_row_type;

    logic        mclk;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        pulseOut;
    logic        dirOut;
    logic [1:0]  rampSel;
    logic        axisBusy;
    logic        axisError;
    logic        originDetermined;
    logic        posComplete;
    logic [15:0] auxCodeWord;
    logic [7:0]  statCode;
    logic        stuck;
    logic        prevDone = 1'b0;
    int          errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          pulses = 0;
    int          lastPulse = 0;
    int          riseCyc = 0;
    int          width = 0;
    int          p0;
    logic [31:0] v;
    axfo_row_type rows [4] = '{
        '{32'h5, 32'h186a0, 32'h2, 16'h007b, 32'h0, 32'h5, 5, 1'b1},
        '{32'hfffffffd, 32'h186a0, 32'h0, 16'hffff, 32'h6, 32'h2, 3, 1'b0},
        '{32'h4, 32'hc350, 32'h3, 16'h0000, 32'h8, 32'h4, 2, 1'b1},
        '{32'h1, 32'h186a0, 32'h1, 16'h04d2, 32'he, 32'h5, 1, 1'b1}};

    // --------------------------------------------------------------
    // Design, host model and clock
    // --------------------------------------------------------------
    axfo_axis_cmd #(.MS_CYCLES(MS)) dut (
        .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pulseOut(pulseOut),
        .dirOut(dirOut), .rampSel(rampSel), .axisBusy(axisBusy),
        .axisError(axisError), .originDetermined(originDetermined),
        .posComplete(posComplete), .auxCodeWord(auxCodeWord),
        .statCode(statCode));

    axfo_host_model host (
        .mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .stuck(stuck));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Counts pulses, times the completion flag and cuts hangs short.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (pulseOut === 1'b1)
        begin
            pulses <= pulses + 1;
            lastPulse <= cyc;
        end
        if (posComplete === 1'b1 && prevDone !== 1'b1)
            riseCyc <= cyc;
        if (posComplete !== 1'b1 && prevDone === 1'b1)
            width <= cyc - riseCyc;
        prevDone <= posComplete;
        if (stuck === 1'b1 || cyc > 90000)
        begin
            errors = errors + 1;
            complete_run();
        end
    end

    // --------------------------------------------------------------
    // Helper tasks
    // --------------------------------------------------------------
    task automatic complete_run();
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got,
                             input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_in(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Pulses a command bit in the control word, then re-arms it.
    task automatic cmd(input logic [31:0] b);
        host.wr(OFS_CONTROL, b);
        host.wr(OFS_CONTROL, 32'h0);
        tick(1);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, v);
        check_val(v, e);
    endtask

    // Waits, bounded, for the completion flag to rise and fall.
    task automatic wait_done();
        int n;
        n = 0;
        while (posComplete !== 1'b1 && n < 20000)
        begin
            @(posedge mclk);
            n++;
        end
        while (posComplete === 1'b1 && n < 20000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20000)
        begin
            errors++;
            complete_run();
        end
        else
            tick(1);
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        tick(1);
        check_val({hreadyout, dirOut, hresp, axisBusy, axisError}, 32'h18);
        check_val({originDetermined, posComplete, statCode}, 32'h0);
        chk_reg(OFS_STATUS, 32'h0);
        host.wr(OFS_SPEED, 32'h186a0);
        host.wr(OFS_TARGET, 32'h5);
        p0 = pulses;
        cmd(32'h2);
        check_val({axisBusy, statCode}, {1'b0, STAT_NO_ORIGIN});
        host.clear_error();
        host.wr(OFS_SELECT, 32'h00010000);
        cmd(32'h1);
        check_val({originDetermined, statCode}, 32'h01);
        host.wr(OFS_SELECT, 32'h0);
        host.clear_error();
        cmd(32'h1);
        check_val({originDetermined, statCode}, 32'h100);
        for (int i = 0; i < 4; i++)
        begin
            host.wr(OFS_TARGET, rows[i].target);
            host.wr(OFS_SPEED, rows[i].speed);
            host.wr(OFS_DWELL, rows[i].dwell);
            host.wr(OFS_AUX_CODE, {16'h0, rows[i].aux});
            host.wr(OFS_MODE, rows[i].mode);
            p0 = pulses;
            cmd(32'h2);
            check_val({axisBusy, rampSel}, {1'b1, rows[i].mode[3:2]});
            check_val(dirOut, rows[i].expDir);
            wait_done();
            check_in(pulses - p0, rows[i].expPulses, rows[i].expPulses);
            check_in(riseCyc - lastPulse, rows[i].dwell * MS,
                     (rows[i].dwell + 2) * MS + 4);
            check_in(width, MS, MS);
            check_val(auxCodeWord, rows[i].aux);
            chk_reg(OFS_POSITION, rows[i].expPos);
            chk_reg(OFS_AUX_OUT, {16'h0, rows[i].aux});
            chk_reg(OFS_MODE, rows[i].mode);
            chk_reg(OFS_TARGET, rows[i].target);
        end
        p0 = pulses;
        cmd(32'h1);
        chk_reg(OFS_POSITION, 32'h0);
        check_in(pulses - p0, 0, 0);
        host.wr(OFS_TARGET, 32'h80000000);
        host.wr(OFS_MODE, 32'h1);
        host.wr(OFS_CONTROL, 32'h2);
        tick(1200);
        check_val({axisBusy, dirOut}, 32'h2);
        host.wr(OFS_CONTROL, 32'h3);
        tick(600);
        host.wr(OFS_CONTROL, 32'h7);
        wait_done();
        chk_reg(OFS_POSITION, 32'(p0 - pulses));
        tick(30);
        check_val(axisBusy, 1'b0);
        host.wr(OFS_CONTROL, 32'h0);
        p0 = p0 - pulses;
        host.wr(OFS_MODE, 32'h0);
        host.wr(OFS_SPEED, 32'h186a1);
        cmd(32'h2);
        check_val({axisError, statCode}, {1'b1, STAT_BAD_VALUE});
        host.wr(OFS_SPEED, 32'h186a0);
        cmd(32'h1);
        chk_reg(OFS_POSITION, 32'(p0));
        cmd(32'h2);
        check_val(axisBusy, 1'b0);
        host.clear_error();
        tick(1);
        check_val({axisError, statCode}, 32'h0);
        host.wr(OFS_DWELL, 32'hc351);
        cmd(32'h2);
        check_val({axisError, statCode}, {1'b1, STAT_BAD_VALUE});
        host.clear_error();
        complete_run();
    end
endmodule // testbench
